/* hdl/stme_pkg.sv */
// constants shared by the standard timer mode engine
package stme_pkg;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL0  = 8'h00;
  localparam logic [7:0] OFF_CTRL1  = 8'h04;
  localparam logic [7:0] OFF_CMPA   = 8'h08;
  localparam logic [7:0] OFF_PERIOD = 8'h0C;
  localparam logic [7:0] OFF_COUNT  = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int C0_PAUSE   = 7;
  localparam int C0_CKS_LO  = 4;
  localparam int C0_ENABLE  = 3;
  localparam int C1_MODE_LO = 6;
  localparam int C1_FUNC_LO = 4;
  localparam int C1_OCTL    = 3;
  localparam int C1_INV     = 2;
  localparam int C1_SWAP    = 1;
  localparam int C1_CLR     = 0;
  localparam int ST_A       = 0;
  localparam int ST_P       = 1;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  RST_CTRL0  = 8'h00;
  localparam logic [7:0]  RST_CTRL1  = 8'h00;
  localparam logic [15:0] RST_CMPA   = 16'h0000;
  localparam logic [7:0]  RST_PERIOD = 8'h00;

  // ****************************************************************
  // encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_CMP = 2'h0,
    MODE_CAP = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TC  = 2'h3
  } stme_mode_t;

  localparam logic [1:0] FUNC_INACT  = 2'h0;
  localparam logic [1:0] FUNC_ACT    = 2'h1;
  localparam logic [1:0] FUNC_PWM    = 2'h2;
  localparam logic [1:0] FUNC_PULSE  = 2'h3;
  localparam logic [1:0] CAP_RISE    = 2'h0;
  localparam logic [1:0] CAP_FALL    = 2'h1;
  localparam logic [1:0] CAP_BOTH    = 2'h2;
  localparam logic [1:0] CMP_LOW     = 2'h1;
  localparam logic [1:0] CMP_HIGH    = 2'h2;
  localparam logic [1:0] CMP_TOGGLE  = 2'h3;

  localparam logic [2:0] CKS_DIV4     = 3'h0;
  localparam logic [2:0] CKS_DIV16    = 3'h2;
  localparam logic [2:0] CKS_DIV64    = 3'h3;
  localparam logic [2:0] CKS_EXT_RISE = 3'h6;
  localparam logic [2:0] CKS_EXT_FALL = 3'h7;

  localparam logic [16:0] FULL_SPAN   = 17'h10000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : stme_pkg

/* hdl/stme_pin_sync.sv */
// two-flop pin synchroniser with edge detection
`timescale 1ns/1ps

module stme_pin_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta;
  logic last;

  // first stage is read only by the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta  <= 1'b0;
      level <= 1'b0;
      last  <= 1'b0;
    end else begin
      meta  <= pin;
      level <= meta;
      last  <= level;
    end
  end

  assign rise = level & ~last;
  assign fall = ~level & last;

endmodule : stme_pin_sync

/* hdl/stme_timer.sv */
// standard timer mode engine with axi4-lite register slave
// Function
// - mode 11 acts like compare-match mode with same flags, pin not driven
// - pwm runs when mode is 10 and output function is 10
// - pwm ignores clear select; swap bit picks period and duty registers
// - pwm sets flag a on every a match, flag p on every p match
// - pwm level bit sets active level, function forces or passes, invert last
// - forced pin levels in pwm leave counter and comparisons running
// - swap clear: period is p times 256 or 65536; duty is a clocks
// - duty at or above period keeps output active whole period
// - swap set: period from a; duty p times 256 or 65536
// - single pulse: external pin active edge sets enable
// - enable rise starts counter and pulse; enable clear ends pulse
// - single pulse: a match clears enable and raises flag a
// - single pulse: counter zeroed only on enable rise; p, clear, swap unused
// - capture mode is 01; enable starts counter; function picks edge
// - capture edge copies counter into compare a and raises flag
// - capture counter free runs; p match zeroes counter, raises flag
// - capture function 11 disables capture, counter keeps running
// - capture drives no output; zero p lets counter reach maximum
// - pwm function codes: inactive, active, pwm, single pulse
// - capture function codes: rise, fall, both, disabled
// - period value supplies bits 15..8 of the period length, multiples of 256
`timescale 1ns/1ps

module stme_timer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ext_clock_pin,
  input  wire logic        timer_io_in,
  output logic             timer_io_out,
  output logic             timer_io_oe
);

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = d[7:0];
    if (strb[1]) r[15:8] = d[15:8];
    return r;
  endfunction : merge16

  function automatic logic mapped(input logic [7:0] a);
    return (a == stme_pkg::OFF_CTRL0) || (a == stme_pkg::OFF_CTRL1) ||
           (a == stme_pkg::OFF_CMPA) || (a == stme_pkg::OFF_PERIOD) ||
           (a == stme_pkg::OFF_COUNT) || (a == stme_pkg::OFF_STATUS);
  endfunction : mapped

  // ****************************************************************
  // registers and state
  // ****************************************************************
  logic [7:0]  ctrl0;
  logic [7:0]  ctrl1;
  logic [15:0] compare_a_value;
  logic [7:0]  period_compare_value;
  logic [15:0] count;
  logic        match_a_flag;
  logic        match_p_flag;
  logic        enable_d;
  logic        cmp_state;
  logic [5:0]  presc;
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  stme_pkg::stme_mode_t mode;
  logic [1:0]  out_func;
  logic        timer_enable;
  logic        next_enable;
  logic        next_aw_hold;
  logic        next_w_hold;
  logic        next_bvalid;
  logic        next_rvalid;
  logic        do_write;
  logic        wr_ctrl0;
  logic        wr_ctrl1;
  logic        wr_cmpa;
  logic        wr_status;
  logic        ext_level;
  logic        ext_rise;
  logic        ext_fall;
  logic        io_level;
  logic        io_rise;
  logic        io_fall;
  logic        ext_edge;
  logic        tick;
  logic        count_en;
  logic        en_rise;
  logic        single;
  logic [16:0] p_len;
  logic [16:0] per_len;
  logic [16:0] duty_len;
  logic [16:0] count_p1;
  logic        a_hit;
  logic        p_hit;
  logic        end_hit;
  logic        a_event;
  logic        p_event;
  logic        cap_event;
  logic        pwm_active;
  logic        next_pin;
  logic        next_oe;

  assign mode         = stme_pkg::stme_mode_t'(ctrl1[stme_pkg::C1_MODE_LO +: 2]);
  assign out_func     = ctrl1[stme_pkg::C1_FUNC_LO +: 2];
  assign timer_enable = ctrl0[stme_pkg::C0_ENABLE];

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  stme_pin_sync u_ext_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (ext_clock_pin),
    .level   (ext_level),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  stme_pin_sync u_io_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (timer_io_in),
    .level   (io_level),
    .rise    (io_rise),
    .fall    (io_fall)
  );

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  assign do_write     = aw_hold & w_hold;
  assign next_aw_hold = do_write ? 1'b0 : (aw_hold | (s_axi_awvalid & s_axi_awready));
  assign next_w_hold  = do_write ? 1'b0 : (w_hold | (s_axi_wvalid & s_axi_wready));
  assign next_bvalid  = do_write | (s_axi_bvalid & ~s_axi_bready);
  assign next_rvalid  = (s_axi_arvalid & s_axi_arready) | (s_axi_rvalid & ~s_axi_rready);
  assign wr_ctrl0     = do_write && aw_addr == stme_pkg::OFF_CTRL0 && w_strb[0];
  assign wr_ctrl1     = do_write && aw_addr == stme_pkg::OFF_CTRL1 && w_strb[0];
  assign wr_cmpa      = do_write && aw_addr == stme_pkg::OFF_CMPA;
  assign wr_status    = do_write && aw_addr == stme_pkg::OFF_STATUS && w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= stme_pkg::RESP_OKAY;
    end else begin
      aw_hold       <= next_aw_hold;
      w_hold        <= next_w_hold;
      s_axi_awready <= ~next_aw_hold & ~next_bvalid;
      s_axi_wready  <= ~next_w_hold & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= mapped(aw_addr) ? stme_pkg::RESP_OKAY : stme_pkg::RESP_SLVERR;
      end
    end
  end

  // read data is a snapshot taken when the address is accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= stme_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rresp <= mapped(s_axi_araddr) ? stme_pkg::RESP_OKAY : stme_pkg::RESP_SLVERR;
        unique case (s_axi_araddr)
          stme_pkg::OFF_CTRL0:  s_axi_rdata <= {24'h000000, ctrl0};
          stme_pkg::OFF_CTRL1:  s_axi_rdata <= {24'h000000, ctrl1};
          stme_pkg::OFF_CMPA:   s_axi_rdata <= {16'h0000, compare_a_value};
          stme_pkg::OFF_PERIOD: s_axi_rdata <= {24'h000000, period_compare_value};
          stme_pkg::OFF_COUNT:  s_axi_rdata <= {16'h0000, count};
          stme_pkg::OFF_STATUS: s_axi_rdata <= {30'h00000000, match_p_flag, match_a_flag};
          default:              s_axi_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************************************
  // clock selection and counter
  // ****************************************************************
  // internal sources are prescaled from aclk; codes 001, 100 and 101 count every aclk
  always_comb begin
    unique case (ctrl0[stme_pkg::C0_CKS_LO +: 3])
      stme_pkg::CKS_DIV4:     tick = presc[1:0] == 2'h3;
      stme_pkg::CKS_DIV16:    tick = presc[3:0] == 4'hF;
      stme_pkg::CKS_DIV64:    tick = presc == 6'h3F;
      stme_pkg::CKS_EXT_RISE: tick = ext_rise;
      stme_pkg::CKS_EXT_FALL: tick = ext_fall;
      default:                tick = 1'b1;
    endcase
  end

  assign single   = mode == stme_pkg::MODE_PWM && out_func == stme_pkg::FUNC_PULSE;
  assign ext_edge = (ctrl0[stme_pkg::C0_CKS_LO +: 3] == stme_pkg::CKS_EXT_FALL) ?
                    ext_fall : ext_rise;
  assign en_rise  = timer_enable & ~enable_d;
  assign count_en = timer_enable & ~ctrl0[stme_pkg::C0_PAUSE] & tick;
  assign count_p1 = {1'b0, count} + 17'h00001;
  // a zero period value means the full 16-bit span
  assign p_len    = (period_compare_value == 8'h00) ? stme_pkg::FULL_SPAN :
                    {1'b0, period_compare_value, 8'h00};
  assign per_len  = (mode == stme_pkg::MODE_PWM && ctrl1[stme_pkg::C1_SWAP]) ?
                    {1'b0, compare_a_value} : p_len;
  assign duty_len = ctrl1[stme_pkg::C1_SWAP] ? p_len : {1'b0, compare_a_value};
  assign a_hit    = count == compare_a_value;
  assign p_hit    = count_p1 == p_len;

  // clear select only matters in compare and timer modes; pwm ignores it
  always_comb begin
    unique case (mode)
      stme_pkg::MODE_CMP,
      stme_pkg::MODE_TC:  end_hit = ctrl1[stme_pkg::C1_CLR] ? a_hit : p_hit;
      stme_pkg::MODE_CAP: end_hit = p_hit;
      stme_pkg::MODE_PWM: end_hit = single ? 1'b0 : (count_p1 == per_len);
    endcase
  end

  assign a_event   = count_en & a_hit & (mode != stme_pkg::MODE_CAP);
  assign p_event   = count_en & p_hit & ~single &
                     ~((mode == stme_pkg::MODE_CMP || mode == stme_pkg::MODE_TC) &&
                       ctrl1[stme_pkg::C1_CLR]);
  assign cap_event = mode == stme_pkg::MODE_CAP && timer_enable &&
                     ((out_func == stme_pkg::CAP_RISE && io_rise) ||
                      (out_func == stme_pkg::CAP_FALL && io_fall) ||
                      (out_func == stme_pkg::CAP_BOTH && (io_rise || io_fall)));

  // counter restarts from zero only on the enable rising edge in single pulse mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count    <= 16'h0000;
      presc    <= 6'h00;
      enable_d <= 1'b0;
    end else begin
      presc    <= presc + 6'h01;
      enable_d <= timer_enable;
      if (en_rise) begin
        count <= 16'h0000;
      end else if (count_en) begin
        count <= end_hit ? 16'h0000 : count_p1[15:0];
      end
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  // hardware set or clear of enable overrides a software write in the same cycle
  always_comb begin
    next_enable = wr_ctrl0 ? w_data[stme_pkg::C0_ENABLE] : timer_enable;
    if (single && ext_edge) next_enable = 1'b1;
    if (single && a_event) next_enable = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0 <= stme_pkg::RST_CTRL0;
    end else begin
      if (wr_ctrl0) ctrl0[7:4] <= w_data[7:4];
      ctrl0[stme_pkg::C0_ENABLE] <= next_enable;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1                <= stme_pkg::RST_CTRL1;
      period_compare_value <= stme_pkg::RST_PERIOD;
    end else begin
      if (wr_ctrl1) ctrl1 <= w_data[7:0];
      if (do_write && aw_addr == stme_pkg::OFF_PERIOD && w_strb[0]) begin
        period_compare_value <= w_data[7:0];
      end
    end
  end

  // a capture in the same cycle as a bus write keeps the captured value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_a_value <= stme_pkg::RST_CMPA;
    end else if (cap_event) begin
      compare_a_value <= count;
    end else if (wr_cmpa) begin
      compare_a_value <= merge16(compare_a_value, w_data, w_strb);
    end
  end

  // status bits are write-one-to-clear; a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end else begin
      match_a_flag <= (a_event | cap_event) |
                      (match_a_flag & ~(wr_status & w_data[stme_pkg::ST_A]));
      match_p_flag <= p_event |
                      (match_p_flag & ~(wr_status & w_data[stme_pkg::ST_P]));
    end
  end

  // ****************************************************************
  // output pin
  // ****************************************************************
  // full duty does not depend on the count, so a shortened period cannot glitch it
  assign pwm_active = ({1'b0, count} < duty_len) || (duty_len >= per_len);

  always_comb begin
    next_pin = 1'b0;
    next_oe  = 1'b0;
    unique case (mode)
      stme_pkg::MODE_PWM: begin
        next_oe = 1'b1;
        unique case (out_func)
          stme_pkg::FUNC_INACT: next_pin = ~ctrl1[stme_pkg::C1_OCTL];
          stme_pkg::FUNC_ACT:   next_pin = ctrl1[stme_pkg::C1_OCTL];
          stme_pkg::FUNC_PWM:   next_pin = pwm_active ~^ ctrl1[stme_pkg::C1_OCTL];
          stme_pkg::FUNC_PULSE: next_pin = timer_enable ~^ ctrl1[stme_pkg::C1_OCTL];
        endcase
        next_pin = next_pin ^ ctrl1[stme_pkg::C1_INV];
      end
      stme_pkg::MODE_CMP: begin
        next_oe  = 1'b1;
        next_pin = cmp_state ^ ctrl1[stme_pkg::C1_INV];
      end
      default: begin
        next_oe  = 1'b0;
        next_pin = 1'b0;
      end
    endcase
  end

  // compare-match pin state: initial level on enable rise, changed by a matches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_state    <= 1'b0;
      timer_io_out <= 1'b0;
      timer_io_oe  <= 1'b0;
    end else begin
      timer_io_out <= next_pin;
      timer_io_oe  <= next_oe;
      if (en_rise) begin
        cmp_state <= ctrl1[stme_pkg::C1_OCTL];
      end else if (a_event && mode == stme_pkg::MODE_CMP) begin
        unique case (out_func)
          stme_pkg::CMP_LOW:    cmp_state <= 1'b0;
          stme_pkg::CMP_HIGH:   cmp_state <= 1'b1;
          stme_pkg::CMP_TOGGLE: cmp_state <= ~cmp_state;
          default:              cmp_state <= cmp_state;
        endcase
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pulse_trigger;
    single && ext_edge && !a_event && !wr_ctrl0 && !timer_enable;
  endsequence

  sequence s_pulse_started;
    timer_enable ##1 enable_d && count == 16'h0000;
  endsequence

  a_pulse_trigger_start: assert property (s_pulse_trigger |=> s_pulse_started)
    else $error("external edge did not start the single pulse");

  a_pulse_end_match: assert property (single && a_event |=> !timer_enable && match_a_flag)
    else $error("a match did not end the single pulse");

  a_pwm_full_duty: assert property (mode == stme_pkg::MODE_PWM && out_func ==
      stme_pkg::FUNC_PWM && duty_len >= per_len
      |=> timer_io_out == $past(ctrl1[stme_pkg::C1_OCTL] ^ ctrl1[stme_pkg::C1_INV]))
    else $error("full duty did not hold the active level");

  a_pwm_forced_run: assert property (mode == stme_pkg::MODE_PWM && out_func ==
      stme_pkg::FUNC_INACT && count_en && !end_hit && !en_rise
      |=> count == $past(count) + 16'h0001 && timer_io_oe)
    else $error("counter stalled while pin forced");

  a_pwm_period_wrap: assert property (mode == stme_pkg::MODE_PWM && !single && count_en &&
      !en_rise && count_p1 == per_len |=> count == 16'h0000)
    else $error("pwm period end did not clear counter");

  a_pwm_p_flag: assert property (mode == stme_pkg::MODE_PWM && !single && count_en && p_hit
      |=> match_p_flag)
    else $error("p match flag missing in pwm");

  a_capture_copy: assert property (cap_event |=> compare_a_value == $past(count)
      && match_a_flag)
    else $error("capture did not copy counter");

  a_capture_off: assert property (mode == stme_pkg::MODE_CAP && out_func ==
      stme_pkg::FUNC_PULSE && !wr_cmpa |=> $stable(compare_a_value))
    else $error("capture happened while disabled");

  a_no_pin_drive: assert property ((mode == stme_pkg::MODE_TC || mode ==
      stme_pkg::MODE_CAP) |=> !timer_io_oe)
    else $error("pin driven in timer or capture mode");

  a_enable_rise_zero: assert property (en_rise |=> count == 16'h0000)
    else $error("enable rise did not zero counter");

endmodule : stme_timer

/* sim/stme_pin_model.sv */
// pin-side model: pulse source on the clock pin, capture source on the timer pin while undriven
`timescale 1ns/1ps
module stme_pin_model (
  input  wire logic aclk,
  input  wire logic trig_cmd,
  input  wire logic cap_cmd,
  input  wire logic timer_io_out,
  input  wire logic timer_io_oe,
  output logic      ext_clock_pin,
  output logic      timer_io_in
);
  // pins move just after an edge, never in step with the sampling edge
  always_ff @(posedge aclk) ext_clock_pin <= trig_cmd;
  // the shared pin shows the design's drive while it is enabled
  assign timer_io_in = timer_io_oe ? timer_io_out : cap_cmd;
endmodule : stme_pin_model

/* sim/tb.sv */
// self-checking bench for the standard timer mode engine
`timescale 1ns/1ps
module tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trig, cap;
  logic        awready, wready, bvalid, arready, rvalid, ext_pin, io_in, io_out, io_oe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, rd2;
  logic [1:0]  bresp, rresp, rs;
  int          failures, samples_checked, hc;

  stme_timer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_clock_pin(ext_pin), .timer_io_in(io_in),
    .timer_io_out(io_out), .timer_io_oe(io_oe));
  stme_pin_model u_pins (.aclk(aclk), .trig_cmd(trig), .cap_cmd(cap),
    .timer_io_out(io_out), .timer_io_oe(io_oe), .ext_clock_pin(ext_pin),
    .timer_io_in(io_in));

  // ****
  // tasks
  // ****
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // a lost answer ends the run instead of hanging it
  task automatic bounded(input int k);
    if (k >= 50) begin
      failures++;
      complete_run();
    end
  endtask : bounded
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50 && bvalid !== 1'b1; k++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    rs = bresp;
    bready <= 1'b0;
    bounded(k);
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50 && rvalid !== 1'b1; k++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
    bounded(k);
  endtask : bus_rd
  task automatic high_count(input int len);
    hc = 0;
    repeat (len) begin
      @(posedge aclk);
      hc += int'(io_out === 1'b1);
    end
  endtask : high_count
  // restart the counter so it never runs past a shortened period, settle one period,
  // then count active cycles over the next
  task automatic pwm(input logic [7:0] c1, input logic [15:0] a, input int len, input int exp);
    bus_wr(stme_pkg::OFF_CMPA, {16'h0, a});
    bus_wr(stme_pkg::OFF_CTRL1, {24'h0, c1});
    bus_wr(stme_pkg::OFF_CTRL0, 32'h10);
    bus_wr(stme_pkg::OFF_CTRL0, 32'h18);
    high_count(len);
    high_count(len);
    check(hc, exp);
    $display("test pwm %h done", c1);
  endtask : pwm

  // ****
  // sequence
  // ****
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, trig, cap} = '0;
    {awaddr, araddr, wdata} = '0;
    failures = 0;
    samples_checked = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    bus_rd(stme_pkg::OFF_CTRL1, rd);
    check(rd, {24'h0, stme_pkg::RST_CTRL1});
    bus_rd(8'h18, rd);
    check({30'h0, rs}, {30'h0, stme_pkg::RESP_SLVERR});
    bus_wr(8'h18, 32'h0);
    check({30'h0, rs}, {30'h0, stme_pkg::RESP_SLVERR});
    $display("test reset done");
    bus_wr(stme_pkg::OFF_PERIOD, 32'h1);
    check({30'h0, rs}, {30'h0, stme_pkg::RESP_OKAY});
    bus_wr(stme_pkg::OFF_CTRL0, 32'h18);
    pwm(8'hA8, 16'h40, 256, 64);
    pwm(8'hA8, 16'h200, 256, 256);
    pwm(8'hAC, 16'h40, 256, 192);
    pwm(8'hA0, 16'h40, 256, 192);
    pwm(8'hA9, 16'h40, 256, 64);
    pwm(8'hAA, 16'h200, 512, 256);
    pwm(8'h98, 16'h40, 256, 256);
    pwm(8'h88, 16'h40, 256, 0);
    check(io_oe, 32'h1);
    bus_wr(stme_pkg::OFF_STATUS, 32'h3);
    repeat (300) @(posedge aclk);
    bus_rd(stme_pkg::OFF_STATUS, rd);
    check(rd, 32'h3);
    bus_wr(stme_pkg::OFF_CTRL0, 32'h10);
    bus_wr(stme_pkg::OFF_CMPA, 32'h20);
    bus_wr(stme_pkg::OFF_CTRL1, 32'hB8);
    bus_wr(stme_pkg::OFF_STATUS, 32'h3);
    trig <= 1'b1;
    high_count(200);
    trig <= 1'b0;
    check(32'(hc >= 32 && hc <= 34), 32'h1);
    bus_rd(stme_pkg::OFF_CTRL0, rd);
    check(rd, 32'h10);
    bus_rd(stme_pkg::OFF_STATUS, rd);
    check(rd[0], 32'h1);
    $display("test pulse done");
    bus_wr(stme_pkg::OFF_PERIOD, 32'h0);
    bus_wr(stme_pkg::OFF_CTRL1, 32'h40);
    bus_wr(stme_pkg::OFF_CTRL0, 32'h18);
    bus_wr(stme_pkg::OFF_STATUS, 32'h3);
    cap <= 1'b1;
    repeat (10) @(posedge aclk);
    bus_rd(stme_pkg::OFF_STATUS, rd);
    check(rd, 32'h1);
    check(io_oe, 32'h0);
    bus_wr(stme_pkg::OFF_CTRL1, 32'h70);
    bus_wr(stme_pkg::OFF_STATUS, 32'h3);
    cap <= 1'b0;
    repeat (10) @(posedge aclk);
    cap <= 1'b1;
    repeat (10) @(posedge aclk);
    bus_rd(stme_pkg::OFF_STATUS, rd);
    check(rd, 32'h0);
    bus_rd(stme_pkg::OFF_COUNT, rd);
    bus_rd(stme_pkg::OFF_COUNT, rd2);
    check(32'(rd2 != rd), 32'h1);
    bus_wr(stme_pkg::OFF_CTRL1, 32'h50);
    cap <= 1'b0;
    repeat (10) @(posedge aclk);
    bus_rd(stme_pkg::OFF_STATUS, rd);
    check(rd, 32'h1);
    bus_wr(stme_pkg::OFF_CTRL1, 32'hC0);
    repeat (5) @(posedge aclk);
    check(io_oe, 32'h0);
    $display("test capture done");
    complete_run();
  end
endmodule : tb
